//--- rtl/tsc_dev.sv
// Device end: transmit subaddress control word with its status bits,
// ping-pong selector and stop/acknowledge handshake.
// Assumes the message engine reports start and end as one-cycle pulses
// on aclk, and that the host drives the link from flops on aclk.
`timescale 1ns/100ps
// Summary of operation
// - Set access flag when message completes
// - Clear access flag on resets, word read
// - Select pointer A or B from buffer select
// - Toggle buffer select after clean ping-pong message
// - Keep select on error, illegal, busy
// - Resets clear buffer select to zero
// - Ignore select outside ping-pong mode
// - Flag broadcast transmit; resets clear it
// - Illegal response depends on detection active
// - Broadcast disabled: address 31 not valid
// - Assert acknowledge when ping-pong active
// - Host never writes acknowledge bit
// - Host stops ping-pong before loading buffer
// - Drop acknowledge on stop request
// - Raise acknowledge when stop released
// - No acknowledge: single buffer, no toggle
// - Host loads circular-2 zero count
// - Decode mode by enable bit priority
// - Block host writes to bits 8-11
// - Low field except bit 3 writable only when idle
module tsc_dev (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link to the host end
	tsc_if.dev link,
	// Message engine events
	input wire logic msg_start, // Transmit command taken, pulse
	input wire logic msg_done, // Message processing ended, pulse
	input wire logic msg_error, // Ended in error, with msg_done
	input wire logic msg_illegal, // Illegal command, with msg_done
	input wire logic msg_busy, // Answered busy, with msg_done
	input wire logic [4:0] cmd_rt_addr, // RT address of command
	input wire logic illegal_detect_on, // Any illegalization bit set
	// Results to the message engine
	output logic cmd_valid, // Command recognised, level
	output logic use_pointer_b, // Data pointer B for this message
	output tsc_pkg::tsc_mode_e buf_mode, // Decoded buffer mode
	output logic broadcast_seen_flag_suppress_data, // Illegal broadcast_seen_flag: no data sent
	output logic make_busy // Busy requested by host
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] cw_r; // The control word
	logic in_msg_r; // A transmit message is under way
	logic clr_all; // Master reset in force
	logic clr_soft; // Soft reset strobe
	logic broadcast_seen_flag_cmd; // Command addressed to broadcast
	logic clean_done; // Error-free completion
	logic pp_mode; // Ping-pong selected
	tsc_pkg::tsc_mode_e mode_nxt; // Decoded mode

	assign clr_all = !link.master_reset_n;
	assign clr_soft = link.soft_reset_cmd;
	assign broadcast_seen_flag_cmd = cmd_rt_addr == tsc_pkg::BROADCAST_SEEN_FLAG_RT_ADDR;
	assign clean_done = msg_done && !msg_error && !msg_illegal && !msg_busy;

	// Mode decode: ping-pong first, then circular 2, circular 1
	always_comb
	begin
		if (cw_r[tsc_pkg::B_PP_EN])
			mode_nxt = tsc_pkg::MODE_PINGPONG;
		else if (cw_r[tsc_pkg::B_CIRC2])
			mode_nxt = tsc_pkg::MODE_CIRC2;
		else if (cw_r[tsc_pkg::B_CIRC1])
			mode_nxt = tsc_pkg::MODE_CIRC1;
		else
			mode_nxt = tsc_pkg::MODE_INDEXED;
	end
	assign pp_mode = mode_nxt == tsc_pkg::MODE_PINGPONG;

	// ----------------------------------------------------------------
	// Message tracking
	// ----------------------------------------------------------------
	// Holds off the handshake while a message uses the buffer
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clr_all)
			in_msg_r <= 1'b0;
		else if (msg_start)
			in_msg_r <= 1'b1;
		else if (msg_done)
			in_msg_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Host-written fields
	// ----------------------------------------------------------------
	// Bits 3, 12, 14, 15 anytime; bits 0-2 and 4-7 only when idle
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clr_all)
		begin
			cw_r[15:12] <= tsc_pkg::CW_RESET[15:12];
			cw_r[7:0] <= tsc_pkg::CW_RESET[7:0];
		end
		else if (link.host_wr)
		begin
			cw_r[15:12] <= link.host_wdata[15:12] & tsc_pkg::WR_ANYTIME[15:12];
			cw_r[tsc_pkg::B_PP_STOP] <= link.host_wdata[tsc_pkg::B_PP_STOP];
			if (!link.terminal_execute)
			begin
				cw_r[7:4] <= link.host_wdata[7:4];
				cw_r[2:0] <= link.host_wdata[2:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Device-owned bits 8 to 11; host writes never reach them
	// ----------------------------------------------------------------
	// Access flag: a completion in the cycle of a read wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clr_all || clr_soft)
			cw_r[tsc_pkg::B_ACCESS] <= 1'b0;
		else if (msg_done && link.terminal_execute)
			cw_r[tsc_pkg::B_ACCESS] <= 1'b1;
		else if (link.host_rd)
			cw_r[tsc_pkg::B_ACCESS] <= 1'b0;
	end

	// Buffer select toggles only after clean ping-pong messages
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clr_all || clr_soft)
			cw_r[tsc_pkg::B_BUF_B] <= 1'b0;
		else if (link.terminal_execute && clean_done && pp_mode &&
			cw_r[tsc_pkg::B_PP_ACK])
			cw_r[tsc_pkg::B_BUF_B] <= !cw_r[tsc_pkg::B_BUF_B];
		// Error, illegal and busy endings leave it alone
	end

	// Broadcast flag; broadcast commands are never valid when disabled
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clr_all || clr_soft)
			cw_r[tsc_pkg::B_BROADCAST_SEEN_FLAG] <= 1'b0;
		else if (msg_start && broadcast_seen_flag_cmd && !link.broadcast_disable &&
			link.terminal_execute)
			cw_r[tsc_pkg::B_BROADCAST_SEEN_FLAG] <= 1'b1;
	end

	// Acknowledge follows the stop request, but only between messages
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clr_all)
			cw_r[tsc_pkg::B_PP_ACK] <= 1'b0;
		else if (!pp_mode)
			cw_r[tsc_pkg::B_PP_ACK] <= 1'b0;
		else if (link.terminal_execute && !in_msg_r && !msg_start)
			cw_r[tsc_pkg::B_PP_ACK] <= !cw_r[tsc_pkg::B_PP_STOP];
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Data appears the cycle after the strobe, before the flag clears
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			link.host_rdata <= tsc_pkg::CW_RESET;
		else if (link.host_rd)
			link.host_rdata <= cw_r;
	end

	// ----------------------------------------------------------------
	// Outputs to the message engine, all registered
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clr_all)
		begin
			cmd_valid <= 1'b0;
			use_pointer_b <= 1'b0;
			buf_mode <= tsc_pkg::MODE_INDEXED;
			broadcast_seen_flag_suppress_data <= 1'b0;
			make_busy <= 1'b0;
		end
		else
		begin
			// Address 31 is not recognised while broadcast is disabled
			cmd_valid <= !(broadcast_seen_flag_cmd && link.broadcast_disable);
			// Select matters only in ping-pong mode
			use_pointer_b <= pp_mode && cw_r[tsc_pkg::B_BUF_B];
			buf_mode <= mode_nxt;
			// With detection on, illegal broadcast sends no data
			broadcast_seen_flag_suppress_data <= broadcast_seen_flag_cmd && !link.broadcast_disable &&
				illegal_detect_on;
			make_busy <= cw_r[tsc_pkg::B_MAKE_BUSY];
		end
	end

endmodule : tsc_dev

//--- rtl/tsc_host.sv
// Host end: AXI4-Lite slave whose registers drive the control word link.
// Assumes software follows the stop/acknowledge handshake via reads.
`timescale 1ns/100ps
module tsc_host (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link to the device end
	tsc_if.hst link,
	// AXI4-Lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [31:0] ctrl_r; // Config bits, strobes kept zero
	logic [15:0] wdata_r; // Word to send
	logic [15:0] rdata_r; // Word captured from the device
	logic [3:0] awaddr_r; // Latched write address
	logic [31:0] wbuf_r; // Latched write data
	logic [3:0] wstrb_r; // Latched strobes
	logic aw_have_r; // Address held
	logic w_have_r; // Data held
	logic rd_wait_r; // Read strobe sent, data next cycle
	logic wr_fire; // Both halves present
	logic [31:0] merged; // Write data under byte strobes
	logic [31:0] old_val; // Target register before the write

	assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

	// Old value of the addressed register for byte merging
	always_comb
	begin
		old_val = 32'h0000_0000;
		if (awaddr_r == tsc_pkg::OFS_CTRL)
			old_val = ctrl_r;
		else if (awaddr_r == tsc_pkg::OFS_WDATA)
			old_val = {16'h0000, wdata_r};
		for (int i = 0; i < 4; i++)
			merged[i*8 +: 8] = wstrb_r[i] ? wbuf_r[i*8 +: 8] : old_val[i*8 +: 8];
	end

	// ----------------------------------------------------------------
	// Write channels: address and data taken in either order
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= 4'h0;
			wbuf_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			// Ready pulses for one cycle when the slot is free
			s_axi_awready <= !aw_have_r && s_axi_awvalid && !s_axi_awready;
			s_axi_wready <= !w_have_r && s_axi_wvalid && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr[3:0];
			end
			else if (wr_fire)
				aw_have_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_r <= 1'b1;
				wbuf_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_have_r <= 1'b0;
		end
	end

	// Write response; unmapped offsets answer with an error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tsc_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			if (awaddr_r == tsc_pkg::OFS_CTRL || awaddr_r == tsc_pkg::OFS_WDATA)
				s_axi_bresp <= tsc_pkg::RESP_OKAY;
			else
				s_axi_bresp <= tsc_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Registers and link strobes
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= tsc_pkg::CTRL_RESET;
			wdata_r <= 16'h0000;
			link.host_wr <= 1'b0;
			link.host_rd <= 1'b0;
			link.soft_reset_cmd <= 1'b0;
			link.host_wdata <= 16'h0000;
		end
		else
		begin
			link.host_wr <= 1'b0;
			link.host_rd <= 1'b0;
			link.soft_reset_cmd <= 1'b0;
			if (wr_fire && awaddr_r == tsc_pkg::OFS_CTRL)
			begin
				// Strobe bits act once and never stay set
				ctrl_r <= {29'h0000_0000, merged[2:0]};
				link.host_wr <= merged[tsc_pkg::C_GO_WR];
				link.host_rd <= merged[tsc_pkg::C_GO_RD];
				link.soft_reset_cmd <= merged[tsc_pkg::C_GO_SR];
				// Device-owned bits are never sent set by the host
				link.host_wdata <= wdata_r & ~tsc_pkg::DEV_OWNED;
			end
			else if (wr_fire && awaddr_r == tsc_pkg::OFS_WDATA)
				wdata_r <= merged[15:0];
		end
	end

	// Config levels straight from flops
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			link.terminal_execute <= 1'b0;
			link.broadcast_disable <= 1'b0;
			link.master_reset_n <= 1'b0;
		end
		else
		begin
			link.terminal_execute <= ctrl_r[tsc_pkg::C_TEXEC];
			link.broadcast_disable <= ctrl_r[tsc_pkg::C_BDIS];
			link.master_reset_n <= !ctrl_r[tsc_pkg::C_MRST];
		end
	end

	// Capture of the word read; software checks the acknowledge here
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_wait_r <= 1'b0;
			rdata_r <= 16'h0000;
		end
		else
		begin
			rd_wait_r <= link.host_rd;
			if (rd_wait_r)
				rdata_r <= link.host_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= tsc_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= tsc_pkg::RESP_OKAY;
				if (s_axi_araddr[3:0] == tsc_pkg::OFS_CTRL)
					s_axi_rdata <= ctrl_r;
				else if (s_axi_araddr[3:0] == tsc_pkg::OFS_WDATA)
					s_axi_rdata <= {16'h0000, wdata_r};
				else if (s_axi_araddr[3:0] == tsc_pkg::OFS_RDATA)
					s_axi_rdata <= {16'h0000, rdata_r};
				else
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= tsc_pkg::RESP_SLVERR;
				end
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule : tsc_host

//--- rtl/tsc_if.sv
// Link between the host controller and the control word logic.
// Assumes both ends run on the same aclk; every signal is a level
// except the one-cycle read, write and soft reset strobes.
`timescale 1ns/100ps
interface tsc_if;
	logic host_rd; // One-cycle read strobe of the control word
	logic host_wr; // One-cycle write strobe
	logic [15:0] host_wdata; // Word to write
	logic [15:0] host_rdata; // Word read, valid one cycle after host_rd
	logic master_reset_n; // Master reset, low active, level
	logic soft_reset_cmd; // One-cycle soft reset strobe
	logic terminal_execute; // Terminal executing
	logic broadcast_disable; // Broadcast commands not recognised

	modport dev (
		input host_rd, host_wr, host_wdata, master_reset_n,
		input soft_reset_cmd, terminal_execute, broadcast_disable,
		output host_rdata
	);
	modport hst (
		output host_rd, host_wr, host_wdata, master_reset_n,
		output soft_reset_cmd, terminal_execute, broadcast_disable,
		input host_rdata
	);
endinterface : tsc_if

//--- rtl/tsc_pkg.sv
// Shared constants for the transmit subaddress control word and its host.
// Assumes one clock (aclk, 10 MHz) and a synchronous active-low reset.
package tsc_pkg;

	// ----------------------------------------------------------------
	// Control word field positions
	// ----------------------------------------------------------------
	localparam int unsigned CW_W = 16; // Control word width
	localparam int unsigned B_IRQ_ZERO = 15; // Interrupt on index zero
	localparam int unsigned B_IRQ_ACCESS = 14; // Interrupt when accessed
	localparam int unsigned B_MAKE_BUSY = 12; // Host busy request
	localparam int unsigned B_ACCESS = 11; // subaddr_access_flag
	localparam int unsigned B_BUF_B = 10; // buffer_b_select
	localparam int unsigned B_BROADCAST_SEEN_FLAG = 9; // broadcast_seen_flag
	localparam int unsigned B_PP_ACK = 8; // pingpong_active_ack
	localparam int unsigned B_ZC_HI = 7; // circ2_zero_count top bit
	localparam int unsigned B_ZC_LO = 4; // circ2_zero_count low bit
	localparam int unsigned B_PP_STOP = 3; // pingpong_stop_request
	localparam int unsigned B_PP_EN = 2; // pingpong_enable
	localparam int unsigned B_CIRC2 = 1; // circ2_enable
	localparam int unsigned B_CIRC1 = 0; // circ1_enable

	// Write masks: bits writable always, and only while not executing
	localparam logic [15:0] WR_ANYTIME = 16'hD008;
	localparam logic [15:0] WR_IDLE_ONLY = 16'h00F7;
	localparam logic [15:0] DEV_OWNED = 16'h0F00;
	localparam logic [15:0] CW_RESET = 16'h0000;
	localparam logic [4:0] BROADCAST_SEEN_FLAG_RT_ADDR = 5'h1F; // Broadcast address 31

	// ----------------------------------------------------------------
	// Buffer modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_INDEXED = 2'b00,
		MODE_CIRC1 = 2'b01,
		MODE_CIRC2 = 2'b10,
		MODE_PINGPONG = 2'b11
	} tsc_mode_e;

	// ----------------------------------------------------------------
	// Host register map (AXI4-Lite byte offsets)
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0; // Config and command bits
	localparam logic [3:0] OFS_WDATA = 4'h4; // Word to write
	localparam logic [3:0] OFS_RDATA = 4'h8; // Word last read back
	localparam int unsigned C_TEXEC = 0; // terminal_execute
	localparam int unsigned C_BDIS = 1; // broadcast_disable
	localparam int unsigned C_MRST = 2; // Hold master reset while 1
	localparam int unsigned C_GO_WR = 8; // Self-clearing: write word
	localparam int unsigned C_GO_RD = 9; // Self-clearing: read word
	localparam int unsigned C_GO_SR = 10; // Self-clearing: soft reset
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : tsc_pkg

//--- tb/tb_tx_subaddr_control_status.sv
// Bench: host end and device end joined by the link, driven over
// AXI4-Lite and through the message engine inputs.
// Assumes package, link and checker compile first.
`timescale 1ns/100ps
module tb_tx_subaddr_control_status;
	typedef struct {
		logic [31:0] d; // Expected data
		logic [31:0] m; // Bits compared
		logic [1:0] r; // Expected response
	} tsc_exp_s;
	logic aclk, aresetn;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic msg_start, msg_done, msg_error, msg_illegal, msg_busy;
	logic [4:0] cmd_rt_addr;
	logic illegal_detect_on, cmd_valid, use_pointer_b;
	logic broadcast_seen_flag_suppress_data, make_busy;
	tsc_pkg::tsc_mode_e buf_mode;
	logic [31:0] cfg; // Last control register value written
	tsc_exp_s rq[$]; // Expected reads, oldest first
	logic [1:0] bq[$]; // Expected write responses
	int bad_count = 0;
	int checked = 0;

	tsc_if link ();
	tsc_host i_tsc_host (
		.aclk, .aresetn, .link(link.hst),
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	tsc_dev i_tsc_dev (
		.aclk, .aresetn, .link(link.dev),
		.msg_start, .msg_done, .msg_error, .msg_illegal, .msg_busy,
		.cmd_rt_addr, .illegal_detect_on, .cmd_valid, .use_pointer_b,
		.buf_mode, .broadcast_seen_flag_suppress_data, .make_busy
	);
	tsc_chk i_tsc_chk (
		.aclk, .aresetn, .host_rd(link.host_rd), .host_wr(link.host_wr),
		.host_wdata(link.host_wdata), .host_rdata(link.host_rdata),
		.master_reset_n(link.master_reset_n),
		.soft_reset_cmd(link.soft_reset_cmd),
		.terminal_execute(link.terminal_execute),
		.broadcast_disable(link.broadcast_disable),
		.msg_start, .msg_done, .cmd_rt_addr, .illegal_detect_on,
		.cmd_valid, .use_pointer_b, .buf_mode, .broadcast_seen_flag_suppress_data
	);

	// 10 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// ----------------------------------------
	// Verdict and comparisons
	// ----------------------------------------
	task automatic test_done;
		if (bad_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %0t write response %h want %h", $time, g, e);
		end
	endtask : cmp_resp
	task automatic cmp_rd(input logic [31:0] g, input logic [1:0] r,
		input tsc_exp_s e);
		checked++;
		if ((g & e.m) !== (e.d & e.m) || r !== e.r)
		begin
			bad_count++;
			$display("BAD %0t read %h/%h want %h/%h", $time, g, r, e.d, e.r);
		end
	endtask : cmp_rd

	// Monitor: each answer is matched with the oldest note
	always @(posedge aclk)
	begin
		if (s_axi_bvalid && s_axi_bready)
			cmp_resp(s_axi_bresp, bq.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			cmp_rd(s_axi_rdata, s_axi_rresp, rq.pop_front());
	end

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	// Bounded wait: a hang counts as a mismatch and ends the run
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 200)
		begin
			bad_count++;
			test_done();
		end
	endtask : tick
	// Address and data offered together, each released when taken
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n = 0;
		bq.push_back(r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			tick(n);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [1:0] r);
		int n = 0;
		rq.push_back('{d, m, r});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			tick(n);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic ctl(input logic [31:0] c);
		cfg = c;
		axi_wr(32'h0, c, tsc_pkg::RESP_OKAY);
	endtask : ctl
	task automatic wr_word(input logic [15:0] w);
		axi_wr(32'h4, {16'h0000, w}, tsc_pkg::RESP_OKAY);
		axi_wr(32'h0, cfg | 32'h100, tsc_pkg::RESP_OKAY);
	endtask : wr_word
	// Read strobe first; the captured word is then fetched
	task automatic rd_word(input logic [15:0] e, input logic [15:0] m);
		axi_wr(32'h0, cfg | 32'h200, tsc_pkg::RESP_OKAY);
		axi_rd(32'h8, {16'h0000, e}, {16'hFFFF, m}, tsc_pkg::RESP_OKAY);
	endtask : rd_word
	task automatic m_start(input logic [4:0] a);
		@(posedge aclk);
		cmd_rt_addr <= a;
		msg_start <= 1'b1;
		@(posedge aclk);
		msg_start <= 1'b0;
	endtask : m_start
	task automatic m_end(input logic [2:0] fl);
		repeat (3) @(posedge aclk);
		msg_done <= 1'b1;
		{msg_error, msg_illegal, msg_busy} <= fl;
		@(posedge aclk);
		msg_done <= 1'b0;
		{msg_error, msg_illegal, msg_busy} <= 3'b000;
	endtask : m_end
	task automatic msg(input logic [4:0] a, input logic [2:0] fl);
		m_start(a);
		m_end(fl);
	endtask : msg

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		logic [15:0] w;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
			s_axi_rready, msg_start, msg_done, msg_error, msg_illegal,
			msg_busy, illegal_detect_on, cmd_rt_addr, s_axi_awaddr,
			s_axi_wdata, s_axi_araddr} = '0;
		void'($urandom(88));
		cfg = 32'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd_word(16'h0000, 16'hFFFF);
		axi_rd(32'h0, tsc_pkg::CTRL_RESET, '1, tsc_pkg::RESP_OKAY);
		axi_wr(32'hC, 32'h1, tsc_pkg::RESP_SLVERR);
		axi_rd(32'hC, 32'h0, '1, tsc_pkg::RESP_SLVERR);
		w = 16'($urandom());
		wr_word(w);
		rd_word(w & 16'hD0FF, 16'hDFFF);
		ctl(32'h1);
		wr_word(16'($urandom()));
		ctl(32'h0);
		for (int k = 0; k < 8; k++)
			wr_word(16'(k));
		wr_word(16'h0000);
		ctl(32'h1);
		msg(5'($urandom_range(30)), 3'b000);
		rd_word(16'h0800, 16'hFFFF);
		rd_word(16'h0000, 16'hFFFF);
		ctl(32'h0);
		wr_word(16'h0004);
		ctl(32'h1);
		rd_word(16'h0104, 16'hFFFF);
		msg(5'h01, 3'b000);
		rd_word(16'h0D04, 16'hFFFF);
		for (int k = 0; k < 3; k++)
		begin
			msg(5'h01, 3'b100 >> k);
			rd_word(16'h0D04, 16'hFFFF);
		end
		m_start(5'h01);
		wr_word(16'h0008);
		rd_word(16'h050C, 16'hFFFF);
		m_end(3'b000);
		rd_word(16'h080C, 16'hFFFF);
		msg(5'h01, 3'b000);
		rd_word(16'h080C, 16'hFFFF);
		wr_word(16'h0004);
		rd_word(16'h0104, 16'hFFFF);
		msg(5'h01, 3'b000);
		rd_word(16'h0D04, 16'hFFFF);
		axi_wr(32'h0, cfg | 32'h400, tsc_pkg::RESP_OKAY);
		rd_word(16'h0104, 16'hFFFF);
		msg(5'h1F, 3'b010);
		rd_word(16'h0B04, 16'hFFFF);
		for (int k = 0; k < 4; k++)
		begin
			ctl(32'h1 | (32'(k[1]) << 1));
			illegal_detect_on <= k[0];
			cmd_rt_addr <= 5'h1F;
			repeat (3) @(posedge aclk);
		end
		axi_wr(32'h0, cfg | 32'h400, tsc_pkg::RESP_OKAY);
		msg(5'h1F, 3'b010);
		rd_word(16'h0904, 16'hFFFF);
		ctl(32'h5);
		ctl(32'h0);
		rd_word(16'h0000, 16'hFFFF);
		repeat (2) @(posedge aclk);
		test_done();
	end
endmodule : tb_tx_subaddr_control_status

//--- tb/tsc_chk.sv
// Assertions on the control word link and on the device results.
// Assumes one clock; the bench instances it beside the link.
`timescale 1ns/100ps
module tsc_chk (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata,
	input wire logic master_reset_n,
	input wire logic soft_reset_cmd,
	input wire logic terminal_execute,
	input wire logic broadcast_disable,
	// Message engine side of the device
	input wire logic msg_start,
	input wire logic msg_done,
	input wire logic [4:0] cmd_rt_addr,
	input wire logic illegal_detect_on,
	input wire logic cmd_valid,
	input wire logic use_pointer_b,
	input wire tsc_pkg::tsc_mode_e buf_mode,
	input wire logic broadcast_seen_flag_suppress_data
);
	// ----------------------------------------
	// Expected state
	// ----------------------------------------
	logic [15:0] sh_r; // Host-owned bits as last written
	logic [15:0] keep; // Bits that a host write leaves alone
	logic acc_r; // Access flag expected
	logic bc_r; // Broadcast flag expected
	logic dcl_r; // Buffer select known to be clear
	logic mdone; // Message ended while executing
	assign keep = terminal_execute ? 16'h0FF7 : 16'h0F00;
	assign mdone = msg_done && terminal_execute;

	// Shadow of writes; device bits are masked off where compared
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !master_reset_n)
			sh_r <= 16'h0000;
		else if (host_wr)
			sh_r <= (sh_r & keep) | (host_wdata & ~keep);
	end

	// Status flags; a set beats a read clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !master_reset_n || soft_reset_cmd)
		begin
			acc_r <= 1'b0;
			bc_r <= 1'b0;
			dcl_r <= 1'b1;
		end
		else
		begin
			acc_r <= mdone || (acc_r && !host_rd);
			bc_r <= bc_r || (msg_start && terminal_execute
				&& cmd_rt_addr == 5'h1F && !broadcast_disable);
			dcl_r <= dcl_r && !mdone;
		end
	end

	// Enable bits decoded by priority
	function automatic tsc_pkg::tsc_mode_e dec(input logic [15:0] b);
		if (b[2])
			return tsc_pkg::MODE_PINGPONG;
		if (b[1])
			return tsc_pkg::MODE_CIRC2;
		if (b[0])
			return tsc_pkg::MODE_CIRC1;
		return tsc_pkg::MODE_INDEXED;
	endfunction : dec

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	host_bits_a: assert property (
		host_rd && master_reset_n |=>
		(host_rdata & 16'hD0FF) == ($past(sh_r) & 16'hD0FF))
		else $error("Host-owned bits read back wrong");
	ack_unwritten_a: assert property (
		host_wr |-> host_wdata[11:8] == 4'h0)
		else $error("Host wrote device-owned bits");
	access_flag_a: assert property (
		host_rd && master_reset_n |=> host_rdata[11] == $past(acc_r))
		else $error("Access flag wrong");
	broadcast_seen_flag_flag_a: assert property (
		host_rd && master_reset_n |=> host_rdata[9] == $past(bc_r))
		else $error("Broadcast flag wrong");
	select_reset_a: assert property (
		host_rd && dcl_r |=> !host_rdata[10])
		else $error("Buffer select not clear after reset");
	mode_decode_a: assert property (
		$past(master_reset_n) |-> buf_mode == dec($past(sh_r)))
		else $error("Buffer mode decode wrong");
	select_ignored_a: assert property (
		buf_mode != tsc_pkg::MODE_PINGPONG |-> !use_pointer_b)
		else $error("Pointer B used outside ping-pong");
	broadcast_seen_flag_valid_a: assert property (
		master_reset_n |=> cmd_valid == !($past(cmd_rt_addr) == 5'h1F
		&& $past(broadcast_disable)))
		else $error("Command valid wrong");
	illegal_resp_a: assert property (
		master_reset_n |=> broadcast_seen_flag_suppress_data == ($past(cmd_rt_addr)
		== 5'h1F && !$past(broadcast_disable) && $past(illegal_detect_on)))
		else $error("Broadcast response choice wrong");
endmodule : tsc_chk
